// ===== hdl/see_consts.vh
// Functional notes
// - Start bit 1, opcode 11 erase, 10 read, 01 write, 00 uses two address bits.
// - x16 uses 7 address bits, 10 or 26 clocks; x8 uses 8, 11 or 19.
// - Start is the first serial clock rise with select and input both high; the code ignores it while a program cycle is busy.
// - Output goes high impedance whenever device select falls.
// - Erase sets the addressed word to ones; low-voltage start at select fall.
// - Select raised after 250 ns low shows busy low, ready high.
// - After completion, a start bit then select low clears ready status.
// - Erase-all sets whole array to ones, self-timed, no clocks needed.
// - Five-volt variant starts erase and erase-all on a clock edge.
// - Programming disabled after power-up until the enable instruction runs.
// - Programming stays enabled until the disable instruction or power loss.
// - Reads work regardless of the enable latch; host should disable afterwards.
// - Read gives a dummy zero then an 8 or 16 bit word.
// - Read data bits change on rising serial clock edges.
// - Holding select high during read streams consecutive words.
// - Write takes 8 or 16 data bits; low-voltage start at select fall.
// - Five-volt variant starts write and write-all on final data bit edge.
// - Write-all erases then writes the word everywhere, only when enabled; the code writes the word in one pass without erasing.
// - A started program cycle completes without further serial clocks.
// - Select low means standby; a running program cycle still completes.
// - Select low at least 250 ns between instructions; low holds control reset.
// - Bits are sampled and launched on rising serial clock edges.
// - Serial clock may halt at either level anywhere without losing state.
// - Clocks with input low before a start bit change nothing.
// - Exact clock count after start, then inputs ignored until next start.
`ifndef SEE_CONSTS_VH
`define SEE_CONSTS_VH

// Opcodes and the extended sub-codes carried in the top address bits.
`define SEE_OP_EXT      2'h0
`define SEE_OP_WRITE    2'h1
`define SEE_OP_READ     2'h2
`define SEE_OP_ERASE    2'h3
`define SEE_EXT_DIS     2'h0
`define SEE_EXT_WALL    2'h1
`define SEE_EXT_EALL    2'h2
`define SEE_EXT_EN      2'h3

// Word width selection for the WID_MODE parameter.
`define SEE_WID_PIN     2'h0
`define SEE_WID_X8      2'h1
`define SEE_WID_X16     2'h2

// Bit counts after the start bit: last indices (count minus one), then full data lengths.
`define SEE_HDR_LAST_X16  5'h08
`define SEE_HDR_LAST_X8   5'h09
`define SEE_DAT_LAST_X16  5'h0F
`define SEE_DAT_LAST_X8   5'h07
`define SEE_DAT_LEN_X16   5'h10
`define SEE_DAT_LEN_X8    5'h08

// Memory geometry and erased value.
`define SEE_MEM_BYTES   9'h100
`define SEE_ERASED      8'hFF

// Clock counts at 50 ns: 250 ns select low, 6 ms program cycle, 15 ms write-all.
// Sized to their registers so no width is lost where they are used.
`define SEE_TCSL_CYC    3'h5
`define SEE_TWC_CYC     20'h1D4C0
`define SEE_TWL_CYC     20'h493E0

`endif

// ===== hdl/see_sync.v
`timescale 1ns/1ps
`include "see_consts.vh"

module see_sync #(
    parameter W = 4
) (
    input  wire         clock,
    input  wire         rstn,
    input  wire [W-1:0] d_in,
    output wire [W-1:0] d_out
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // Two flops per pin; the first stage feeds only the second.
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= d_in;
            sync_q <= meta_q;
        end
    end

    assign d_out = sync_q;

endmodule

// ===== hdl/see_engine.v
`timescale 1ns/1ps
`include "see_consts.vh"

module see_engine #(
    parameter [19:0] PROG_CYCLES = `SEE_TWC_CYC,
    parameter [19:0] FILL_CYCLES = `SEE_TWL_CYC,
    parameter [1:0]  WID_MODE    = `SEE_WID_PIN,
    parameter        EARLY_START = 1'b0
) (
    input  wire clock,
    input  wire rstn,
    input  wire device_select,
    input  wire serial_clock,
    input  wire serial_in,
    input  wire width_select_pin,
    output reg  serial_out,
    output reg  serial_out_oe_n
);

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_HDR  = 3'h1;
    localparam [2:0] ST_DATA = 3'h2;
    localparam [2:0] ST_READ = 3'h3;
    localparam [2:0] ST_DONE = 3'h4;
    localparam [2:0] TCSL    = `SEE_TCSL_CYC;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and edge finding.
    ////////////////////////////////////////////////////////////////////////////

    wire [3:0] sync_w;
    wire       cs_s;
    wire       sk_s;
    wire       si_s;
    wire       ws_s;
    reg        cs_q;
    reg        sk_q;

    see_sync #(
        .W (4)
    ) u_sync (
        .clock (clock),
        .rstn  (rstn),
        .d_in  ({device_select, serial_clock, serial_in, width_select_pin}),
        .d_out (sync_w)
    );

    assign cs_s  = sync_w[3];
    assign sk_s  = sync_w[2];
    assign si_s  = sync_w[1];
    assign ws_s  = sync_w[0];

    // Previous levels; the serial clock is only ever edge-detected, so a halt is harmless.
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cs_q <= 1'b0;
            sk_q <= 1'b0;
        end else begin
            cs_q <= cs_s;
            sk_q <= sk_s;
        end
    end

    wire sk_rise = sk_s & ~sk_q;
    wire cs_fall = ~cs_s & cs_q;
    wire cs_rise = cs_s & ~cs_q;

    ////////////////////////////////////////////////////////////////////////////
    // Shared state and decode.
    ////////////////////////////////////////////////////////////////////////////

    reg  [7:0]  mem [0:255];
    reg  [2:0]  state_q;
    reg  [4:0]  cnt_q;
    reg  [9:0]  sh_q;
    reg  [1:0]  op_q;
    reg  [1:0]  ext_q;
    reg  [7:0]  addr_q;
    reg  [15:0] data_q;
    reg         wide_q;
    reg         en_q;
    reg         pend_q;
    reg         go_q;
    reg         stat_q;
    reg         clr_arm_q;
    reg         rdy_clr_q;
    reg  [15:0] rd_sh_q;
    reg  [4:0]  rd_cnt_q;
    reg  [2:0]  cslow_q;
    reg         busy_q;
    reg         rdy_q;
    reg  [19:0] timer_q;
    reg  [8:0]  sweep_q;
    reg  [1:0]  p_op_q;
    reg  [1:0]  p_ext_q;
    reg  [7:0]  p_addr_q;
    reg  [15:0] p_data_q;
    reg         p_wide_q;

    // Byte index of one half of a word; x8 words are single bytes.
    function [7:0] byte_idx;
        input       wide;
        input [7:0] a;
        input       lo;
        begin
            byte_idx = wide ? {a[6:0], lo} : a;
        end
    endfunction

    wire        wide_now = (WID_MODE == `SEE_WID_X16) |
                           ((WID_MODE == `SEE_WID_PIN) & ws_s);
    wire [9:0]  hbits    = {sh_q[8:0], si_s};
    wire [1:0]  h_op     = wide_q ? hbits[8:7] : hbits[9:8];
    wire [1:0]  h_ext    = wide_q ? hbits[6:5] : hbits[7:6];
    wire [7:0]  h_addr   = wide_q ? {1'b0, hbits[6:0]} : hbits[7:0];
    wire [4:0]  hdr_last = wide_q ? `SEE_HDR_LAST_X16 : `SEE_HDR_LAST_X8;
    wire [4:0]  dat_last = wide_q ? `SEE_DAT_LAST_X16 : `SEE_DAT_LAST_X8;
    wire [4:0]  dat_len  = wide_q ? `SEE_DAT_LEN_X16 : `SEE_DAT_LEN_X8;
    wire [15:0] rd_word  = wide_q ?
                           {mem[byte_idx(1'b1, addr_q, 1'b0)], mem[byte_idx(1'b1, addr_q, 1'b1)]} :
                           {mem[addr_q], 8'h00};
    wire        hdr_done = (state_q == ST_HDR) & sk_rise & (cnt_q == hdr_last);
    wire        dat_done = (state_q == ST_DATA) & sk_rise & (cnt_q == dat_last);

    ////////////////////////////////////////////////////////////////////////////
    // Select low time, measured so status is shown only after a proper gap.
    ////////////////////////////////////////////////////////////////////////////

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cslow_q <= 3'h0;
        end else if (cs_s) begin
            cslow_q <= 3'h0;
        end else if (cslow_q != TCSL) begin
            cslow_q <= cslow_q + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Instruction sequencer. Select low clears it; the enable latch survives.
    ////////////////////////////////////////////////////////////////////////////

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q         <= ST_IDLE;
            cnt_q           <= 5'h00;
            sh_q            <= 10'h000;
            op_q            <= `SEE_OP_EXT;
            ext_q           <= `SEE_EXT_DIS;
            addr_q          <= 8'h00;
            data_q          <= 16'h0000;
            wide_q          <= 1'b0;
            en_q            <= 1'b0;
            pend_q          <= 1'b0;
            go_q            <= 1'b0;
            stat_q          <= 1'b0;
            clr_arm_q       <= 1'b0;
            rdy_clr_q       <= 1'b0;
            rd_sh_q         <= 16'h0000;
            rd_cnt_q        <= 5'h00;
            serial_out      <= 1'b0;
            serial_out_oe_n <= 1'b1;
        end else begin
            go_q      <= 1'b0;
            rdy_clr_q <= 1'b0;
            if (!cs_s) begin
                // Standby: control reset, output released, unfinished work dropped.
                state_q         <= ST_IDLE;
                cnt_q           <= 5'h00;
                stat_q          <= 1'b0;
                serial_out_oe_n <= 1'b1;
                clr_arm_q       <= 1'b0;
                pend_q          <= 1'b0;
                if (cs_fall && pend_q) begin
                    go_q <= 1'b1;
                end
                if (cs_fall && clr_arm_q) begin
                    rdy_clr_q <= 1'b1;
                end
            end else begin
                if (cs_rise && (cslow_q == TCSL) && (busy_q || rdy_q)) begin
                    stat_q          <= 1'b1;
                    serial_out_oe_n <= 1'b0;
                    serial_out      <= ~busy_q;
                end else if (stat_q && (state_q != ST_READ)) begin
                    serial_out <= ~busy_q;
                end
                case (state_q)
                    ST_IDLE: begin
                        // Start bits are ignored until the running cycle ends.
                        if (sk_rise && si_s && !busy_q) begin
                            state_q   <= ST_HDR;
                            cnt_q     <= 5'h00;
                            wide_q    <= wide_now;
                            clr_arm_q <= rdy_q;
                        end
                    end
                    ST_HDR: begin
                        if (sk_rise) begin
                            sh_q  <= hbits;
                            cnt_q <= cnt_q + 5'h01;
                        end
                        if (hdr_done) begin
                            op_q   <= h_op;
                            ext_q  <= h_ext;
                            addr_q <= h_addr;
                            cnt_q  <= 5'h00;
                            state_q <= ST_DONE;
                            case (h_op)
                                `SEE_OP_READ: begin
                                    state_q         <= ST_READ;
                                    stat_q          <= 1'b0;
                                    serial_out      <= 1'b0;
                                    serial_out_oe_n <= 1'b0;
                                    rd_cnt_q        <= 5'h00;
                                end
                                `SEE_OP_WRITE: begin
                                    state_q <= ST_DATA;
                                end
                                `SEE_OP_ERASE: begin
                                    if (en_q) begin
                                        go_q   <= EARLY_START;
                                        pend_q <= ~EARLY_START;
                                    end
                                end
                                default: begin
                                    case (h_ext)
                                        `SEE_EXT_EN:   en_q <= 1'b1;
                                        `SEE_EXT_DIS:  en_q <= 1'b0;
                                        `SEE_EXT_WALL: state_q <= ST_DATA;
                                        default: begin
                                            if (en_q) begin
                                                go_q   <= EARLY_START;
                                                pend_q <= ~EARLY_START;
                                            end
                                        end
                                    endcase
                                end
                            endcase
                        end
                    end
                    ST_DATA: begin
                        if (sk_rise) begin
                            data_q <= {data_q[14:0], si_s};
                            cnt_q  <= cnt_q + 5'h01;
                        end
                        if (dat_done) begin
                            state_q <= ST_DONE;
                            if (en_q) begin
                                go_q   <= EARLY_START;
                                pend_q <= ~EARLY_START;
                            end
                        end
                    end
                    ST_READ: begin
                        if (sk_rise) begin
                            if (rd_cnt_q == 5'h00) begin
                                serial_out <= rd_word[15];
                                rd_sh_q    <= {rd_word[14:0], 1'b0};
                                rd_cnt_q   <= dat_len - 5'h01;
                                if (!wide_q && (dat_len == 5'h01)) begin
                                    addr_q <= addr_q + 8'h01;
                                end
                            end else begin
                                serial_out <= rd_sh_q[15];
                                rd_sh_q    <= {rd_sh_q[14:0], 1'b0};
                                rd_cnt_q   <= rd_cnt_q - 5'h01;
                                if (rd_cnt_q == 5'h01) begin
                                    // Word finished; the next edge fetches the following one.
                                    addr_q <= wide_q ? {1'b0, addr_q[6:0] + 7'h01} :
                                              addr_q + 8'h01;
                                end
                            end
                        end
                    end
                    ST_DONE: begin
                        // Further clocks are ignored until select drops.
                        state_q <= ST_DONE;
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Self-timed program engine. Runs on the system clock alone.
    ////////////////////////////////////////////////////////////////////////////

    wire p_all   = (p_op_q == `SEE_OP_EXT);
    wire p_fill  = (p_op_q == `SEE_OP_ERASE) |
                   (p_all & (p_ext_q == `SEE_EXT_EALL));
    wire p_hit   = p_all |
                   (sweep_q[7:0] == byte_idx(p_wide_q, p_addr_q, 1'b0)) |
                   (sweep_q[7:0] == byte_idx(p_wide_q, p_addr_q, 1'b1));
    wire [7:0] p_byte = p_fill ? `SEE_ERASED :
                        (p_wide_q & ~sweep_q[0]) ? p_data_q[15:8] : p_data_q[7:0];

    // The sweep covers every byte early in the cycle; the timer sets the length.
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            busy_q   <= 1'b0;
            rdy_q    <= 1'b0;
            timer_q  <= 20'h00000;
            sweep_q  <= `SEE_MEM_BYTES;
            p_op_q   <= `SEE_OP_EXT;
            p_ext_q  <= `SEE_EXT_DIS;
            p_addr_q <= 8'h00;
            p_data_q <= 16'h0000;
            p_wide_q <= 1'b0;
        end else begin
            if (go_q && !busy_q) begin
                busy_q   <= 1'b1;
                timer_q  <= ((op_q == `SEE_OP_EXT) && (ext_q == `SEE_EXT_WALL)) ?
                            FILL_CYCLES : PROG_CYCLES;
                sweep_q  <= 9'h000;
                p_op_q   <= op_q;
                p_ext_q  <= ext_q;
                p_addr_q <= addr_q;
                p_data_q <= data_q;
                p_wide_q <= wide_q;
            end else if (busy_q) begin
                timer_q <= timer_q - 20'h00001;
                if (timer_q == 20'h00001) begin
                    busy_q <= 1'b0;
                end
                if (sweep_q != `SEE_MEM_BYTES) begin
                    sweep_q <= sweep_q + 9'h001;
                end
            end
            // A cycle starting in the clearing cycle keeps its ready flag.
            if (go_q) begin
                rdy_q <= 1'b1;
            end else if (rdy_clr_q && !busy_q) begin
                rdy_q <= 1'b0;
            end
        end
    end

    // Array writes; the array itself has no reset, like real cells.
    always @(posedge clock) begin
        if (busy_q && (sweep_q != `SEE_MEM_BYTES) && p_hit) begin
            mem[sweep_q[7:0]] <= p_byte;
        end
    end

endmodule

// ===== testbench/see_engine_assertions.sv
`timescale 1ns/1ps
// Port checker for the serial command engine; it watches only the top-level pins.
module see_engine_assertions #(
    parameter [19:0] FILL_CYCLES = 20'h00258
) (
    input wire clock,
    input wire rstn,
    input wire device_select,
    input wire serial_clock,
    input wire serial_in,
    input wire width_select_pin,
    input wire serial_out,
    input wire serial_out_oe_n
);
    reg [19:0] busy_cnt_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////
    // Length of the current driven-low run; a busy flag that never clears shows as a long run.
    always @(posedge clock or negedge rstn) begin
        if (!rstn)
            busy_cnt_q <= 20'h00000;
        else if (!serial_out_oe_n && !serial_out)
            busy_cnt_q <= busy_cnt_q + 20'h00001;
        else
            busy_cnt_q <= 20'h00000;
    end
    ////////////////////////////////////////
    // The pin stays released from reset until a select arrives.
    a_reset_pin_free: assert property ($rose(rstn) |-> serial_out_oe_n)
        else $error("output driven right after reset");
    a_oe_release: assert property ($fell(device_select) |-> ##[1:4] serial_out_oe_n)
        else $error("output still driven after deselect");
    a_idle_hiz: assert property ((!device_select) [*5] |-> serial_out_oe_n)
        else $error("output driven while deselected");
    a_drive_needs_sel: assert property ($fell(serial_out_oe_n) |->
        device_select && $past(device_select, 2))
        else $error("output enabled without select");
    a_rise_only_deselect: assert property ($rose(serial_out_oe_n) |->
        !$past(device_select))
        else $error("output released while still selected");
    a_dummy_zero: assert property ($fell(serial_out_oe_n) && $past(serial_clock) |->
        !serial_out)
        else $error("read did not begin with a zero bit");
    a_data_on_rise: assert property ($fell(serial_out) && !serial_out_oe_n &&
        $past(!serial_out_oe_n) |-> $past(serial_clock) || $past(serial_clock, 2))
        else $error("read bit changed away from a serial clock rise");
    a_busy_bounded: assert property (busy_cnt_q <= FILL_CYCLES + 20'h00008)
        else $error("busy held longer than the program timer");
    c_read_start: cover property ($fell(serial_out_oe_n) && $past(serial_clock));
    c_ready_seen: cover property ($rose(serial_out) && !serial_out_oe_n && !serial_clock);
    c_long_busy: cover property (busy_cnt_q == 20'h00100);
endmodule

bind see_engine see_engine_assertions #(.FILL_CYCLES(FILL_CYCLES)) u_see_chk (
    .clock(clock),
    .rstn(rstn),
    .device_select(device_select),
    .serial_clock(serial_clock),
    .serial_in(serial_in),
    .width_select_pin(width_select_pin),
    .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n)
);

// ===== testbench/see_host_model.sv
`timescale 1ns/1ps
// Host side of the three-wire link; the serial clock runs only inside frames.
module see_host_model (
    input  wire clock,
    input  wire serial_out,
    input  wire serial_out_oe_n,
    output reg  device_select,
    output reg  serial_clock,
    output reg  serial_in,
    output reg  pin_level
);
    reg last_q = 1'b0;
    initial begin
        device_select = 1'b0;
        serial_clock = 1'b0;
        serial_in = 1'b0;
    end
    // A released pin shows the inverse of its last value, so stale data never passes.
    always @(posedge clock) if (!serial_out_oe_n) last_q <= serial_out;
    always @* pin_level = serial_out_oe_n ? ~last_q : serial_out;
    task tick(input integer n);
        repeat (n) @(posedge clock);
    endtask
    // One 400 ns bit: data settles 200 ns before the rise and holds 200 ns after it.
    task bit_io(input b, output r);
        begin
            serial_in <= b;
            tick(4);
            serial_clock <= 1'b1;
            tick(4);
            r = pin_level;
            serial_clock <= 1'b0;
        end
    endtask
    // Whole frame, MSB first, then the mandatory deselect time.
    task frame(input [63:0] bits, input integer n, output [31:0] rd);
        integer i;
        reg     r;
        begin
            rd = 32'h00000000;
            device_select <= 1'b1;
            tick(2);
            for (i = n - 1; i >= 0; i = i - 1) begin
                bit_io(bits[i], r);
                rd = {rd[30:0], r};
            end
            tick(2);
            device_select <= 1'b0;
            tick(6);
        end
    endtask
    // Status poll after a low time, then a start bit and deselect to clear ready.
    task poll(output s0, output s1, output integer w);
        reg r;
        begin
            device_select <= 1'b1;
            tick(5);
            s0 = pin_level;
            w = 0;
            while (pin_level !== 1'b1 && w < 3000) begin
                tick(1);
                w = w + 1;
            end
            s1 = pin_level;
            bit_io(1'b1, r);
            tick(2);
            device_select <= 1'b0;
            tick(6);
        end
    endtask
endmodule

// ===== testbench/see_engine_tb_top.sv
`timescale 1ns/1ps
`include "see_consts.vh"
module see_engine_tb_top;
    localparam integer PROG  = 300;
    localparam integer FILL  = 600;
    localparam integer LIMIT = 20000;
    reg         clock;
    reg         rstn;
    reg         width_select_pin;
    wire        device_select;
    wire        serial_clock;
    wire        serial_in;
    wire        serial_out;
    wire        serial_out_oe_n;
    wire        pin_level;
    integer     bad_count;
    integer     num_checks;
    integer     seed;
    integer     cycles;
    integer     i;
    integer     w;
    reg  [7:0]  exp_mem [0:255];
    reg  [31:0] rd;
    reg  [6:0]  a;
    reg  [7:0]  b;
    reg  [15:0] d;
    reg         s0;
    reg         s1;
    see_host_model host (
        .clock(clock),
        .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n),
        .device_select(device_select),
        .serial_clock(serial_clock),
        .serial_in(serial_in),
        .pin_level(pin_level)
    );
    see_engine #(.PROG_CYCLES(20'h0012C), .FILL_CYCLES(20'h00258), .WID_MODE(`SEE_WID_PIN),
                 .EARLY_START(1'b0)) uut (
        .clock(clock),
        .rstn(rstn),
        .device_select(device_select),
        .serial_clock(serial_clock),
        .serial_in(serial_in),
        .width_select_pin(width_select_pin),
        .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n)
    );
    ////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Hang guard; the planned run needs about two fifths of the limit.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            bad_count = bad_count + 1;
            conclude;
        end
    end
    task conclude;
        begin
            $display("checks %0d mismatches %0d", num_checks, bad_count);
            if (bad_count == 0 && num_checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    function [15:0] w16(input [6:0] wa);
        w16 = {exp_mem[{wa, 1'b0}], exp_mem[{wa, 1'b1}]};
    endfunction
    // Sends the top n of len bits, with two idle low bits before the start bit.
    task send(input [25:0] cw, input integer len, input integer n);
        host.frame(cw >> (len - n), n + 2, rd);
    endtask
    // Two-word sequential read; the second word checks address wrap when ra is 7'h7F.
    task read16(input [6:0] ra);
        begin
            host.frame({22'h000000, 1'b1, `SEE_OP_READ, ra, 32'h00000000}, 42, rd);
            check(rd, {w16(ra), w16(ra + 7'h01)});
        end
    endtask
    task status(input integer cyc);
        begin
            host.poll(s0, s1, w);
            check(s0, 1'b0);
            check(s1, 1'b1);
            check((w > cyc - 20) && (w < cyc + 5), 1'b1);
        end
    endtask
    ////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        width_select_pin = 1'b1;
        bad_count = 0;
        num_checks = 0;
        seed = 7250;
        cycles = 0;
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        repeat (2) @(posedge clock);
        // Unlock, erase the whole array, read across the top address.
        send({1'b1, `SEE_OP_EXT, 7'h60, 16'h0000}, 26, 10);
        send({1'b1, `SEE_OP_EXT, 7'h40, 16'h0000}, 26, 10);
        status(PROG);
        for (i = 0; i < 256; i = i + 1) exp_mem[i] = 8'hFF;
        read16(7'h7F);
        $display("test erase_all done");
        // Writes at the top address and at random ones.
        for (i = 0; i < 3; i = i + 1) begin
            a = (i == 0) ? 7'h7F : $random(seed);
            d = $random(seed);
            send({1'b1, `SEE_OP_WRITE, a, d}, 26, 26);
            status(PROG);
            {exp_mem[{a, 1'b0}], exp_mem[{a, 1'b1}]} = d;
            read16(a);
        end
        $display("test write done");
        // Single erase, then a write cut short by deselect.
        send({1'b1, `SEE_OP_ERASE, a, 16'h0000}, 26, 10);
        status(PROG);
        {exp_mem[{a, 1'b0}], exp_mem[{a, 1'b1}]} = 16'hFFFF;
        send({1'b1, `SEE_OP_WRITE, a, ~d}, 26, 20);
        read16(a);
        $display("test erase_abandon done");
        // Locked again: a write is refused while reads still work.
        send({1'b1, `SEE_OP_EXT, 7'h00, 16'h0000}, 26, 10);
        send({1'b1, `SEE_OP_WRITE, a, 16'h1234}, 26, 26);
        read16(a);
        $display("test lock done");
        // Write-all with a random word, read back at a random place.
        send({1'b1, `SEE_OP_EXT, 7'h60, 16'h0000}, 26, 10);
        d = $random(seed);
        send({1'b1, `SEE_OP_EXT, 7'h20, d}, 26, 26);
        status(FILL);
        for (i = 0; i < 128; i = i + 1) {exp_mem[2 * i], exp_mem[2 * i + 1]} = d;
        a = $random(seed);
        read16(a);
        $display("test write_all done");
        // Mid-run reset: the enable latch must come back cleared, the array kept.
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        repeat (2) @(posedge clock);
        send({1'b1, `SEE_OP_WRITE, a, ~d}, 26, 26);
        read16(a);
        $display("test reset done");
        // Byte organisation through the width pin.
        width_select_pin <= 1'b0;
        b = $random(seed);
        d = $random(seed);
        send({7'h00, 1'b1, `SEE_OP_EXT, 8'hC0, 8'h00}, 19, 11);
        send({7'h00, 1'b1, `SEE_OP_WRITE, b, d[7:0]}, 19, 19);
        status(PROG);
        exp_mem[b] = d[7:0];
        host.frame({37'h0, 1'b1, `SEE_OP_READ, b, 16'h0000}, 27, rd);
        check(rd & 32'h0000FFFF, {16'h0000, exp_mem[b], exp_mem[b + 8'h01]});
        $display("test byte_mode done");
        conclude;
    end
endmodule
